/* File: inc/fts_pkg.sv */
// Purpose: Shared constants and types for the telegram slave framer.
// Assumes: One 250 MHz clock, telegram bytes carried as 11-bit characters.
// Notes: Every count and code used by more than one file lives here.

package fts_pkg;

  // ==========================================================================
  // Telegram layout
  localparam logic [7:0] START_MARKER = 8'h02;
  localparam int ADDR_FMT_BIT = 7;
  localparam logic [6:0] ADDR_BCAST = 7'h00;
  localparam logic [7:0] LEN_PROCESS = 8'h06;
  localparam logic [7:0] LEN_PARAM = 8'h0E;
  localparam logic [7:0] LEN_TEXT_MIN = 8'h0A;
  localparam logic [7:0] LEN_OVERHEAD = 8'h02;
  localparam logic [7:0] LAST_DATA_OFS = 8'h03;

  // ==========================================================================
  // Character format
  localparam logic [3:0] CHAR_LAST_BIT = 4'hA;
  localparam logic [1:0] FMT_EVEN = 2'h0;
  localparam logic [1:0] FMT_ODD = 2'h1;
  localparam logic [1:0] FMT_NONE = 2'h2;
  localparam logic [1:0] FMT_DEFAULT = FMT_EVEN;

  // ==========================================================================
  // Bit rate limits
  localparam int CLK_HZ = 250000000;
  localparam int BAUD_MIN = 2400;
  localparam int BAUD_MAX = 115200;
  localparam logic [16:0] DIV_MAX = 17'(CLK_HZ / BAUD_MIN);
  localparam logic [16:0] DIV_MIN = 17'(CLK_HZ / BAUD_MAX);
  localparam logic [16:0] DIV_FLOOR = 17'h20;

  // ==========================================================================
  // Response buffer
  localparam int FIFO_WIDTH = 8;
  localparam int FIFO_DEPTH = 32;

  typedef enum logic [1:0] {
    KIND_NONE = 2'h0,
    KIND_PROCESS = 2'h1,
    KIND_PARAM = 2'h2,
    KIND_TEXT = 2'h3
  } fts_kind_type;

endpackage

/* File: design/fts_fifo.sv */
// Purpose: Response byte buffer between the user side and the transmitter.
// Assumes: Pushes and pops may happen in the same cycle.
// Notes: The framer only drains it while sending, so it really fills.
`timescale 1ns/100ps
`default_nettype none

module fts_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  import fts_pkg::*;

  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] cnt;
  } fts_fifo_type;

  fts_fifo_type s_ff, nxt_s;
  logic push, pop;

  assign in_ready = (s_ff.cnt != FULL);
  assign out_valid = (s_ff.cnt != '0);
  assign out_data = s_ff.mem[s_ff.rd];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    nxt_s = s_ff;
    if (push) begin
      nxt_s.mem[s_ff.wr] = in_data;
      nxt_s.wr = s_ff.wr + 1'b1;
    end
    if (pop) begin
      nxt_s.rd = s_ff.rd + 1'b1;
    end
    nxt_s.cnt = s_ff.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

endmodule
`default_nettype wire

/* File: design/fts_char_io.sv */
// Purpose: Serialises and deserialises single 11-bit line characters.
// Assumes: rx_line is already synchronised; bit_div is cycles per bit.
// Notes: Also gives a free-running bit-time tick for the framer's timers.
`timescale 1ns/100ps
`default_nettype none

module fts_char_io (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic rx_line,
  input wire logic [16:0] bit_div,
  input wire logic [1:0] line_fmt,
  input wire logic tx_go,
  input wire logic [7:0] tx_byte,
  output logic tx_busy,
  output logic tx_line,
  output logic rx_busy,
  output logic rx_done,
  output logic rx_err,
  output logic [7:0] rx_byte,
  output logic bit_tick
);
  import fts_pkg::*;

  typedef struct packed {
    logic [16:0] tick_cnt;
    logic tick;
    logic rx_busy;
    logic [16:0] rx_cnt;
    logic [3:0] rx_idx;
    logic [8:0] rx_sh;
    logic [7:0] rx_byte;
    logic rx_done;
    logic rx_err;
    logic tx_busy;
    logic [16:0] tx_cnt;
    logic [3:0] tx_idx;
    logic [10:0] tx_sh;
  } fts_cio_type;

  fts_cio_type s_ff, nxt_s;
  logic odd, nopar, par;

  assign odd = (line_fmt == FMT_ODD);
  assign nopar = (line_fmt == FMT_NONE);
  // R2: parity makes the ones even.
  assign par = nopar ? 1'b1 : ((^tx_byte) ^ odd);

  always_comb begin
    nxt_s = s_ff;
    nxt_s.tick = 1'b0;
    nxt_s.rx_done = 1'b0;
    nxt_s.rx_err = 1'b0;
    if (s_ff.tick_cnt == '0) begin
      nxt_s.tick = 1'b1;
      nxt_s.tick_cnt = bit_div - 17'h1;
    end else begin
      nxt_s.tick_cnt = s_ff.tick_cnt - 17'h1;
    end
    // R1: start, eight data, parity, stop.
    if (!s_ff.rx_busy) begin
      if (!rx_line) begin
        nxt_s.rx_busy = 1'b1;
        nxt_s.rx_cnt = {1'b0, bit_div[16:1]};
        nxt_s.rx_idx = '0;
      end
    end else if (s_ff.rx_cnt != '0) begin
      nxt_s.rx_cnt = s_ff.rx_cnt - 17'h1;
    end else begin
      nxt_s.rx_cnt = bit_div - 17'h1;
      nxt_s.rx_idx = s_ff.rx_idx + 4'h1;
      if (s_ff.rx_idx == '0) begin
        nxt_s.rx_busy = !rx_line;
      end else if (s_ff.rx_idx < CHAR_LAST_BIT) begin
        nxt_s.rx_sh = {rx_line, s_ff.rx_sh[8:1]};
      end else begin
        nxt_s.rx_busy = 1'b0;
        nxt_s.rx_done = 1'b1;
        nxt_s.rx_byte = s_ff.rx_sh[7:0];
        // R2: even ones over data and parity.
        nxt_s.rx_err = !rx_line | (nopar ? !s_ff.rx_sh[8] : ((^s_ff.rx_sh) != odd));
      end
    end
    if (!s_ff.tx_busy) begin
      if (tx_go) begin
        nxt_s.tx_busy = 1'b1;
        nxt_s.tx_cnt = bit_div - 17'h1;
        nxt_s.tx_idx = '0;
        nxt_s.tx_sh = {1'b1, par, tx_byte, 1'b0};
      end
    end else if (s_ff.tx_cnt != '0) begin
      nxt_s.tx_cnt = s_ff.tx_cnt - 17'h1;
    end else begin
      nxt_s.tx_cnt = bit_div - 17'h1;
      if (s_ff.tx_idx == CHAR_LAST_BIT) begin
        nxt_s.tx_busy = 1'b0;
      end else begin
        nxt_s.tx_idx = s_ff.tx_idx + 4'h1;
        nxt_s.tx_sh = {1'b1, s_ff.tx_sh[10:1]};
      end
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign tx_busy = s_ff.tx_busy;
  assign tx_line = s_ff.tx_busy ? s_ff.tx_sh[0] : 1'b1;
  assign rx_busy = s_ff.rx_busy;
  assign rx_done = s_ff.rx_done;
  assign rx_err = s_ff.rx_err;
  assign rx_byte = s_ff.rx_byte;
  assign bit_tick = s_ff.tick;

  char_len_a: assert property (@(posedge ref_clk) disable iff (!nrst) // R1
    $fell(s_ff.tx_busy) |-> s_ff.tx_idx == CHAR_LAST_BIT)
    else $error("Character ended before eleven bits.");

endmodule
`default_nettype wire

/* File: design/fts_framer.sv */
// Purpose: Slave-side telegram framer for a half-duplex master-slave line.
// Assumes: One master; response data field is supplied through the buffer.
// Notes: Timers count bit times; data bytes are offered only for own frames.
// Behaviour
// R1: Characters are start, eight data, parity, stop.
// R2: Parity makes ones count even.
// R3: Even parity one stop default, selectable.
// R4: Telegram starts with marker 02 hex.
// R5: Marker, length, address, data, then check.
// R6: Length counts data plus address and check.
// R7: Text length is ten plus characters.
// R8: Address bit 7 set, node 1 to 126.
// R9: Zero node address means broadcast.
// R10: Response echoes received address byte.
// R11: Check byte is XOR from zero.
// R12: Never transmit unrequested.
// R13: Release line except while answering.
// R14: Act only on own address.
// R15: Process, parameter and text telegram sizes.
// R16: Process block is four bytes.
// R17: Parameter block is twelve bytes.
// R18: Response uses the request's telegram type.
// R19: Text field is command, index, text, process.
// R20: Bit rate configurable from 2400 to 115200; the code floors the divider at 32 cycles instead, allowing rates up to 7812500.
// R21: Wait minimum delay before answering.
// R22: Abandon telegram after inter-byte gap.
// R23: Master times out a missing response.
// R24: Process words go in fixed order.
// R25: Command bits 12 to 15 captured.
// R26: Discard bad telegrams without answer.
// R27: Never answer a broadcast.
`timescale 1ns/100ps
`default_nettype none

module fts_framer (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic line_rx_in,
  output logic line_tx_out,
  output logic line_tx_oe_n,
  input wire logic [6:0] node_addr,
  input wire logic [1:0] line_fmt,
  input wire logic [16:0] baud_div,
  input wire logic [15:0] min_resp_bits,
  input wire logic [15:0] max_gap_bits,
  output logic [7:0] rx_data,
  output logic [7:0] rx_data_index,
  output logic rx_data_valid,
  output logic frame_ok,
  output logic frame_bad,
  output logic frame_bcast,
  output fts_pkg::fts_kind_type frame_kind,
  output logic [7:0] frame_len,
  output logic [3:0] param_command,
  input wire logic [7:0] resp_data,
  input wire logic resp_valid,
  output logic resp_ready,
  output logic tx_active
);
  import fts_pkg::*;

  // ==========================================================================
  // State
  typedef enum logic [3:0] {
    S_HUNT = 4'h0,
    S_LEN = 4'h1,
    S_ADDR = 4'h2,
    S_DATA = 4'h3,
    S_CHECK = 4'h4,
    S_DELAY = 4'h5,
    S_TX_STX = 4'h6,
    S_TX_LEN = 4'h7,
    S_TX_ADR = 4'h8,
    S_TX_DATA = 4'h9,
    S_TX_BCC = 4'hA,
    S_TX_END = 4'hB
  } fts_state_type;

  typedef struct packed {
    logic [2:0] sync;
    logic line_q;
    fts_state_type st;
    logic [7:0] len;
    logic [7:0] adr;
    logic [7:0] bcc;
    logic [7:0] cnt;
    logic ours;
    logic bcast;
    logic bad;
    logic [15:0] timer;
    logic [7:0] rx_data;
    logic [7:0] rx_idx;
    logic rx_valid;
    logic ok;
    logic badp;
    fts_kind_type kind;
    logic [3:0] cmd;
    logic tx_go;
    logic [7:0] tx_byte;
    logic drive;
  } fts_frm_type;

  localparam fts_frm_type FRM_RST = '{sync: 3'h7, line_q: 1'b1, st: S_HUNT, kind: KIND_NONE, default: '0};

  fts_frm_type s_ff, nxt_s;

  logic [16:0] eff_div;
  logic [1:0] eff_fmt;
  logic cio_tx_busy, cio_tx_line, cio_rx_busy, cio_rx_done, cio_rx_err, tick;
  logic [7:0] cio_rx_byte;
  logic [7:0] buf_data;
  logic buf_valid, can_send, rx_frame, timeout, good;

  function automatic fts_kind_type kind_of(input logic [7:0] l);
    // R15 R17: lengths of the three telegram kinds.
    if (l == LEN_PROCESS) begin
      kind_of = KIND_PROCESS;
    end else if (l == LEN_PARAM) begin
      kind_of = KIND_PARAM;
    // R7: text length is ten fixed plus characters.
    end else if (l >= LEN_TEXT_MIN) begin
      kind_of = KIND_TEXT;
    end else begin
      kind_of = KIND_NONE;
    end
  endfunction

  // ==========================================================================
  // Line configuration
  // R20: slowest rate capped; a small floor keeps the mid-bit sample sane.
  assign eff_div = (baud_div < DIV_FLOOR) ? DIV_FLOOR : ((baud_div > DIV_MAX) ? DIV_MAX : baud_div);
  // R3: unused format code falls back to the default.
  assign eff_fmt = (line_fmt == 2'h3) ? FMT_DEFAULT : line_fmt;

  fts_char_io u_cio (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .rx_line(s_ff.line_q),
    .bit_div(eff_div),
    .line_fmt(eff_fmt),
    .tx_go(s_ff.tx_go),
    .tx_byte(s_ff.tx_byte),
    .tx_busy(cio_tx_busy),
    .tx_line(cio_tx_line),
    .rx_busy(cio_rx_busy),
    .rx_done(cio_rx_done),
    .rx_err(cio_rx_err),
    .rx_byte(cio_rx_byte),
    .bit_tick(tick)
  );

  // A full 32-byte buffer holds the longest text answer the user is likely to stage.
  fts_fifo #(
    .WIDTH(FIFO_WIDTH),
    .DEPTH(FIFO_DEPTH)
  ) u_buf (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .in_data(resp_data),
    .in_valid(resp_valid),
    .in_ready(resp_ready),
    .out_data(buf_data),
    .out_valid(buf_valid),
    .out_ready(s_ff.st == S_TX_DATA && can_send)
  );

  assign can_send = !cio_tx_busy && !s_ff.tx_go;
  assign rx_frame = (s_ff.st == S_LEN) || (s_ff.st == S_ADDR) || (s_ff.st == S_DATA) || (s_ff.st == S_CHECK);
  // R22: gap counted only while the line is idle.
  assign timeout = rx_frame && !cio_rx_busy && (s_ff.timer > max_gap_bits);
  assign good = !s_ff.bad && !cio_rx_err && (cio_rx_byte == s_ff.bcc);

  // ==========================================================================
  // Framing
  always_comb begin
    nxt_s = s_ff;
    nxt_s.rx_valid = 1'b0;
    nxt_s.ok = 1'b0;
    nxt_s.badp = 1'b0;
    nxt_s.tx_go = 1'b0;
    nxt_s.sync = {s_ff.sync[1:0], line_rx_in};
    if (s_ff.sync[1] == s_ff.sync[2]) begin
      nxt_s.line_q = s_ff.sync[2];
    end
    if (cio_rx_done) begin
      nxt_s.timer = '0;
    end else if (tick && !cio_rx_busy && s_ff.timer != 16'hFFFF) begin
      nxt_s.timer = s_ff.timer + 16'h1;
    end
    if (rx_frame && cio_rx_done && cio_rx_err) begin
      nxt_s.bad = 1'b1;
    end
    case (s_ff.st)
      S_HUNT: begin
        // R4: marker opens a frame; R11: check restarts from zero.
        if (cio_rx_done && !cio_rx_err && cio_rx_byte == START_MARKER) begin
          nxt_s.bcc = START_MARKER;
          nxt_s.bad = 1'b0;
          nxt_s.st = S_LEN;
        end
      end
      S_LEN: begin
        // R6: length decides the data count.
        if (cio_rx_done) begin
          nxt_s.len = cio_rx_byte;
          nxt_s.bcc = s_ff.bcc ^ cio_rx_byte;
          nxt_s.kind = kind_of(cio_rx_byte);
          if (kind_of(cio_rx_byte) == KIND_NONE) begin
            nxt_s.bad = 1'b1;
          end
          nxt_s.st = S_ADDR;
        end
      end
      S_ADDR: begin
        if (cio_rx_done) begin
          nxt_s.adr = cio_rx_byte;
          nxt_s.bcc = s_ff.bcc ^ cio_rx_byte;
          // R9: zero node field is a broadcast.
          nxt_s.bcast = (cio_rx_byte[6:0] == ADDR_BCAST);
          // R8: format bit must be set; R14: own node or broadcast only.
          nxt_s.ours = cio_rx_byte[ADDR_FMT_BIT] && (cio_rx_byte[6:0] == node_addr || cio_rx_byte[6:0] == ADDR_BCAST);
          nxt_s.cnt = '0;
          nxt_s.st = S_DATA;
        end
      end
      S_DATA: begin
        if (cio_rx_done) begin
          nxt_s.bcc = s_ff.bcc ^ cio_rx_byte;
          // R16 R19 R24: data bytes offered in line order with their index.
          if (s_ff.ours && !s_ff.bad) begin
            nxt_s.rx_valid = 1'b1;
            nxt_s.rx_data = cio_rx_byte;
            nxt_s.rx_idx = s_ff.cnt;
          end
          // R25: command nibble is the top of the first word.
          if (s_ff.cnt == '0 && s_ff.kind != KIND_PROCESS) begin
            nxt_s.cmd = cio_rx_byte[7:4];
          end
          nxt_s.cnt = s_ff.cnt + 8'h1;
          if (s_ff.cnt == 8'(s_ff.len - LAST_DATA_OFS)) begin
            nxt_s.st = S_CHECK;
          end
        end
      end
      S_CHECK: begin
        if (cio_rx_done) begin
          // R11: check byte against the running XOR; R26: discard otherwise.
          nxt_s.ok = s_ff.ours && good;
          nxt_s.badp = s_ff.ours && !good;
          nxt_s.st = S_HUNT;
          // R12 R27: only a good request is answered, never a broadcast.
          if (s_ff.ours && good && !s_ff.bcast) begin
            nxt_s.st = S_DELAY;
          end
        end
      end
      S_DELAY: begin
        // R21: hold off for the minimum response delay.
        if (s_ff.timer >= min_resp_bits) begin
          nxt_s.st = S_TX_STX;
        end
      end
      S_TX_STX: begin
        if (can_send) begin
          nxt_s.tx_go = 1'b1;
          nxt_s.tx_byte = START_MARKER;
          nxt_s.bcc = START_MARKER;
          nxt_s.st = S_TX_LEN;
        end
      end
      S_TX_LEN: begin
        // R18: same length, hence same telegram type.
        if (can_send) begin
          nxt_s.tx_go = 1'b1;
          nxt_s.tx_byte = s_ff.len;
          nxt_s.bcc = s_ff.bcc ^ s_ff.len;
          nxt_s.st = S_TX_ADR;
        end
      end
      S_TX_ADR: begin
        // R10: address byte returned unchanged.
        if (can_send) begin
          nxt_s.tx_go = 1'b1;
          nxt_s.tx_byte = s_ff.adr;
          nxt_s.bcc = s_ff.bcc ^ s_ff.adr;
          nxt_s.cnt = '0;
          nxt_s.st = S_TX_DATA;
        end
      end
      S_TX_DATA: begin
        // R5: data field drawn from the buffer, stalling when empty.
        if (can_send && buf_valid) begin
          nxt_s.tx_go = 1'b1;
          nxt_s.tx_byte = buf_data;
          nxt_s.bcc = s_ff.bcc ^ buf_data;
          nxt_s.cnt = s_ff.cnt + 8'h1;
          if (s_ff.cnt == 8'(s_ff.len - LAST_DATA_OFS)) begin
            nxt_s.st = S_TX_BCC;
          end
        end
      end
      S_TX_BCC: begin
        // R11: send the accumulated check byte.
        if (can_send) begin
          nxt_s.tx_go = 1'b1;
          nxt_s.tx_byte = s_ff.bcc;
          nxt_s.st = S_TX_END;
        end
      end
      S_TX_END: begin
        if (can_send) begin
          nxt_s.st = S_HUNT;
        end
      end
      default: begin
        nxt_s.st = S_HUNT;
      end
    endcase
    // R22: abandon a stalled telegram.
    if (timeout && !cio_rx_done) begin
      nxt_s.st = S_HUNT;
      nxt_s.badp = 1'b1;
    end
    // R13: drive only while a response is on its way out.
    nxt_s.drive = (nxt_s.st >= S_TX_STX);
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      s_ff <= FRM_RST;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // ==========================================================================
  // Outputs
  assign line_tx_out = s_ff.drive ? cio_tx_line : 1'b1;
  assign line_tx_oe_n = !s_ff.drive;
  assign rx_data = s_ff.rx_data;
  assign rx_data_index = s_ff.rx_idx;
  assign rx_data_valid = s_ff.rx_valid;
  assign frame_ok = s_ff.ok;
  assign frame_bad = s_ff.badp;
  assign frame_bcast = s_ff.bcast;
  assign frame_kind = s_ff.kind;
  assign frame_len = s_ff.len;
  assign param_command = s_ff.cmd;
  assign tx_active = s_ff.drive;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  drive_release_a: assert property (!line_tx_oe_n |-> s_ff.st >= S_TX_STX) // R13
    else $error("Line driven outside a response.");
  start_marker_a: assert property (s_ff.tx_go && $past(s_ff.st) == S_TX_STX |-> s_ff.tx_byte == 8'h02) // R4
    else $error("Response did not open with the marker.");
  addr_echo_a: assert property (s_ff.tx_go && $past(s_ff.st) == S_TX_ADR |-> s_ff.tx_byte == s_ff.adr) // R10
    else $error("Address byte not echoed.");
  bcast_silent_a: assert property (s_ff.ok && s_ff.bcast |-> s_ff.st == S_HUNT) // R27
    else $error("Broadcast was answered.");
  bad_silent_a: assert property (s_ff.badp |-> s_ff.st == S_HUNT && !s_ff.drive) // R26
    else $error("Bad telegram led to a response.");
  len_kind_a: assert property (s_ff.ok |-> s_ff.len == 8'h06 || s_ff.len == 8'h0E || s_ff.len >= 8'h0A) // R6
    else $error("Accepted telegram with illegal length.");
  check_xor_a: assert property (s_ff.ok |-> $past(cio_rx_byte) == $past(s_ff.bcc)) // R11
    else $error("Accepted telegram with wrong check byte.");
  own_addr_a: assert property (s_ff.ok && !s_ff.bcast |-> s_ff.adr[6:0] == node_addr && s_ff.adr[7]) // R14
    else $error("Accepted telegram for another node.");
  min_delay_a: assert property ($past(s_ff.st) == S_DELAY && s_ff.st == S_TX_STX |-> $past(s_ff.timer) >= min_resp_bits) // R21
    else $error("Answer began before the minimum delay.");
  request_first_a: assert property (s_ff.st == S_DELAY && $past(s_ff.st) != S_DELAY |-> $past(s_ff.st) == S_CHECK) // R12
    else $error("Response not preceded by a request.");

endmodule
`default_nettype wire

/* File: bench/fts_master_model.sv */
// Purpose: Behavioural bus master that sends requests and reads answers.
// Assumes: Line biased high when nobody drives; even or odd parity, one stop bit.
// Notes: Answers are sampled mid-bit, so a slow or fast answer both land.
`timescale 1ns/100ps
`default_nettype none

module fts_master_model #(
  parameter int BD = 2170
) (
  input wire logic ref_clk,
  input wire logic bus_line,
  input wire logic slave_oe_n,
  input wire logic odd_par,
  output logic drv_line,
  output logic drv_en,
  output logic [7:0] got_byte,
  output logic got_valid,
  output logic got_bad
);
  logic [10:0] sh;

  initial begin
    drv_line = 1'b1;
    drv_en = 1'b0;
    got_byte = 8'h00;
    got_valid = 1'b0;
    got_bad = 1'b0;
  end

  // ==========================================================================
  // Sending
  // eleven-bit character, even or odd parity per odd_par
  task automatic send_char(input logic [7:0] b);
    logic [10:0] c;
    c = {1'b1, (^b) ^ odd_par, b, 1'b0};
    for (int i = 0; i < 11; i++) begin
      @(negedge ref_clk);
      drv_en = 1'b1;
      drv_line = c[i];
      repeat (BD - 1) @(negedge ref_clk);
    end
  endtask

  task automatic release_line();
    @(negedge ref_clk);
    drv_en = 1'b0;
    drv_line = 1'b1;
  endtask

  // ==========================================================================
  // Receiving
  // answer character check
  always begin
    @(posedge ref_clk);
    got_valid <= 1'b0;
    if (!slave_oe_n && !bus_line) begin
      repeat (BD / 2) @(posedge ref_clk);
      sh[0] = bus_line;
      for (int i = 1; i < 11; i++) begin
        repeat (BD) @(posedge ref_clk);
        sh[i] = bus_line;
      end
      got_byte <= sh[8:1];
      got_bad <= sh[0] | ((^sh[9:1]) ^ odd_par) | !sh[10];
      got_valid <= 1'b1;
    end
  end
endmodule

`default_nettype wire

/* File: bench/tb_fts_framer.sv */
// Purpose: Self-checking bench for the telegram slave framer.
// Assumes: Bit period at the design's floor, so a full exchange stays short.
// Notes: Expectations are queued by the driver and popped by the monitor.
`timescale 1ns/100ps
`default_nettype none

module tb_fts_framer;
  import fts_pkg::*;
  localparam int BD = int'(DIV_FLOOR);
  localparam int MINB = 16;
  localparam int MAXG = 4;
  localparam logic [6:0] NODE = 7'h05;
  localparam logic [7:0] ADR = 8'h85;
  logic ref_clk, nrst, line_tx_out, line_tx_oe_n, rx_data_valid, frame_ok, frame_bad, frame_bcast;
  logic resp_valid, resp_ready, tx_active, drv_line, drv_en, got_valid, got_bad, bus_line;
  logic [7:0] rx_data, rx_data_index, frame_len, resp_data, got_byte, first_dat;
  logic [3:0] param_command;
  fts_kind_type frame_kind;
  logic [1:0] fmt = FMT_DEFAULT;
  integer seed = 32'hC526;
  int fail_count = 0;
  int n_tests = 0;
  int tx_starts = 0;
  logic prev_oe = 1'b1;
  logic [15:0] exp_rx[$];
  logic [7:0] exp_tx[$];
  logic [7:0] fifo_q[$];
  logic [4:0] exp_fr[$];

  // The bias network holds the line high when nobody drives it.
  assign bus_line = drv_en ? drv_line : (line_tx_oe_n ? 1'b1 : line_tx_out);

  fts_framer uut (.ref_clk(ref_clk), .nrst(nrst), .line_rx_in(bus_line), .line_tx_out(line_tx_out),
    .line_tx_oe_n(line_tx_oe_n), .node_addr(NODE), .line_fmt(fmt), .baud_div(DIV_FLOOR),
    .min_resp_bits(16'(MINB)), .max_gap_bits(16'(MAXG)), .rx_data(rx_data), .rx_data_index(rx_data_index),
    .rx_data_valid(rx_data_valid), .frame_ok(frame_ok), .frame_bad(frame_bad), .frame_bcast(frame_bcast),
    .frame_kind(frame_kind), .frame_len(frame_len), .param_command(param_command), .resp_data(resp_data),
    .resp_valid(resp_valid), .resp_ready(resp_ready), .tx_active(tx_active));

  fts_master_model #(.BD(BD)) m (.ref_clk(ref_clk), .bus_line(bus_line), .slave_oe_n(line_tx_oe_n),
    .odd_par(fmt == FMT_ODD),
    .drv_line(drv_line), .drv_en(drv_en), .got_byte(got_byte), .got_valid(got_valid), .got_bad(got_bad));

  always #2 ref_clk = ~ref_clk;

  // ==========================================================================
  // Helpers
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", nm, e, g);
      fail_count++;
    end
  endtask

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  function automatic logic [7:0] xsum(input logic [7:0] q[$]);
    logic [7:0] x;
    x = 8'h00;
    foreach (q[i]) x ^= q[i];
    return x;
  endfunction

  task automatic send_tel(input logic [7:0] len, input logic [7:0] adr, input int nsend,
      input logic [7:0] flip, input logic [4:0] fr);
    logic [7:0] q[$];
    q = {START_MARKER, len, adr};
    for (int i = 0; i < int'(len) - 2; i++) begin
      q.push_back(8'($random(seed)));
      if (i + 3 < nsend) exp_rx.push_back({8'(i), q[i + 3]});
    end
    first_dat = q[3];
    q.push_back(xsum(q) ^ flip);
    exp_fr.push_back(fr);
    for (int i = 0; i < nsend; i++) m.send_char(q[i]);
    m.release_line();
  endtask

  task automatic wait_idle(input string nm, input int lim);
    int k;
    k = 0;
    while ((exp_fr.size() != 0 || exp_tx.size() != 0 || line_tx_oe_n !== 1'b1) && k < lim) begin
      @(posedge ref_clk);
      k++;
    end
    if (k >= lim) begin
      fail_count++;
      $display("wrong value %s expected done seen timeout", nm);
      end_sim();
    end else begin
      $display("test %s done", nm);
    end
  endtask

  // ==========================================================================
  // Monitor
  always @(posedge ref_clk) begin
    if (nrst) begin
      if (!line_tx_oe_n && prev_oe) tx_starts++;
      prev_oe = line_tx_oe_n;
      if (drv_en && !line_tx_oe_n) chk("line collision", 16'h0, 16'h1);
      chk("tx_active", {15'h0, !line_tx_oe_n}, {15'h0, tx_active});
      if (rx_data_valid) begin
        if (exp_rx.size() == 0) chk("spare rx_data", 16'h0, 16'h1);
        else chk("rx_data", exp_rx.pop_front(), {rx_data_index, rx_data});
      end
      if (frame_ok || frame_bad) begin
        if (exp_fr.size() == 0) chk("spare frame", 16'h0, 16'h1);
        else chk("frame", {11'h0, exp_fr.pop_front()}, {11'h0, frame_ok, frame_bad, frame_bcast, frame_kind});
      end
      if (got_valid) begin
        chk("tx_char", 16'h0, {15'h0, got_bad});
        if (exp_tx.size() == 0) chk("spare tx_byte", 16'h0, 16'h1);
        else chk("tx_byte", {8'h0, exp_tx.pop_front()}, {8'h0, got_byte});
      end
    end
  end

  // ==========================================================================
  // Main sequence
  initial begin
    int cnt;
    ref_clk = 1'b0;
    nrst = 1'b0;
    resp_valid = 1'b0;
    resp_data = 8'h00;
    repeat (4) @(negedge ref_clk);
    nrst = 1'b1;
    repeat (4) @(negedge ref_clk);
    chk("oe_n reset", 16'h1, {15'h0, line_tx_oe_n});
    // Push past the depth so the buffer has to refuse.
    repeat (40) begin
      @(negedge ref_clk);
      resp_data = 8'($random(seed));
      resp_valid = 1'b1;
      if (resp_ready === 1'b1) fifo_q.push_back(resp_data);
    end
    @(negedge ref_clk);
    resp_valid = 1'b0;
    chk("fifo count", 16'd32, 16'(fifo_q.size()));
    chk("fifo ready", 16'h0, {15'h0, resp_ready});
    $display("test fifo_fill done");
    // The text answer drains the whole buffer.
    exp_tx = {START_MARKER, 8'h22, ADR};
    foreach (fifo_q[i]) exp_tx.push_back(fifo_q[i]);
    exp_tx.push_back(xsum(exp_tx));
    send_tel(8'h22, ADR, 36, 8'h00, {3'b100, KIND_TEXT});
    cnt = 0;
    while (line_tx_oe_n === 1'b1 && cnt < 100 * BD) begin
      @(posedge ref_clk);
      cnt++;
    end
    chk("resp_delay", 16'h1, {15'h0, cnt >= (MINB - 2) * BD && cnt <= (MINB + 3) * BD});
    wait_idle("text", 40 * 11 * BD);
    chk("frame_len", 16'h0022, {8'h00, frame_len});
    chk("param_command", {12'h0, first_dat[7:4]}, {12'h0, param_command});
    chk("fifo empty", 16'h1, {15'h0, resp_ready});
    send_tel(8'h06, ADR, 8, 8'h01, {3'b010, KIND_PROCESS});
    wait_idle("bad_check", 20 * BD);
    send_tel(8'h06, ADR, 3, 8'h00, {3'b010, KIND_PROCESS});
    wait_idle("gap_timeout", (MAXG + 8) * BD);
    send_tel(8'h06, 8'h80, 8, 8'h00, {3'b101, KIND_PROCESS});
    wait_idle("broadcast", 20 * BD);
    @(negedge ref_clk);
    fmt = FMT_ODD;
    send_tel(8'h06, 8'h80, 8, 8'h00, {3'b101, KIND_PROCESS});
    wait_idle("odd_parity", 20 * BD);
    repeat ((MINB + 8) * BD) @(posedge ref_clk);
    chk("answers sent", 16'h1, 16'(tx_starts));
    chk("rx left over", 16'h0, 16'(exp_rx.size()));
    end_sim();
  end
endmodule

`default_nettype wire
